// ### common/logic_engine_cfg.svh
// register map and timing constants of the scan-cycle logic engine
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef LOGIC_ENGINE_CFG_SVH
`define LOGIC_ENGINE_CFG_SVH

`define ADDR_CTRL      8'h00
`define ADDR_FLAG_WR   8'h04
`define ADDR_FLAG_RD   8'h08
`define ADDR_STATUS    8'h0C
`define ADDR_GCFG0     8'h10
`define ADDR_GCFG3     8'h1C
`define ADDR_KEYS      8'h20
`define ADDR_SHIFT     8'h24
`define ADDR_NDI_LO    8'h28
`define ADDR_NDI_HI    8'h2C
`define ADDR_NDO_LO    8'h30
`define ADDR_NDO_HI    8'h34
`define ADDR_AIDX      8'h38
`define ADDR_ADATA     8'h3C

`define CTRL_RUN_BIT     0
`define CTRL_CSCFG_BIT   1
`define CTRL_CSUSED_BIT  2
`define CTRL_RESET       3'h0
`define FLAG_RESET       8'h00
`define GCFG_RESET       12'h000
`define CYCLE_TIME_NS    160
`define CLK_PERIOD_NS    10

`endif

// ### common/logic_engine_pkg.sv
// types shared by the scan-cycle logic engine
// assumes logic_engine_cfg.svh for numeric constants
package logic_engine_pkg;

    typedef struct packed {
        logic charset;
        logic red_panel;
        logic red_base;
        logic amber_panel;
        logic amber_base;
        logic white_panel;
        logic white_base;
        logic startup;
    } flags_s;

    typedef struct packed {
        logic [3:0] panel_key;
        logic [3:0] cursor_key;
    } keys_s;

    typedef enum logic [1:0] {
        SRC_OPEN = 2'b00,
        SRC_PIN  = 2'b01,
        SRC_LO   = 2'b10,
        SRC_HI   = 2'b11
    } src_e;

    typedef struct packed {
        logic inv;
        src_e src;
    } pin_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FIRST = 2'b01,
        ST_RUN   = 2'b10
    } seq_e;

endpackage

// ### src/logic_engine.sv
// scan-cycle logic engine: special flags, shift bits, keys, network i/o, basic gates
// assumes an avalon-mm master with waitrequest and synchronous inputs on clk
// Operation
// - startup flag high during first cycle only
// - later, startup flag behaves as ordinary flag
// - white flag lights white backlight
// - amber flag lights amber backlight
// - red flag lights red backlight
// - charset flag picks first or second set
// - unused charset flag: configured set applies
// - flags show previous cycle, held all cycle
// - network writes flags; charset needs program use
// - 32 shift bits, read-only, shift function writes
// - four cursor keys, panel equals base
// - four panel function keys as inputs
// - 64/32/64/16 network digital/analog inputs/outputs
// - every gate input individually invertible
// - and gives 1 only when all 1
// - open and/nand inputs read as 1
// - edge and: all 1 now, some 0 before
// - nand gives 0 only when all 1
// - or: any 1; open inputs read 0
// - nor: all 0; open inputs read 0
// - xor: inputs differ; open inputs read 0
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
`include "logic_engine_cfg.svh"

module logic_engine #(
    parameter int CYCLE_CLKS = `CYCLE_TIME_NS / `CLK_PERIOD_NS,
    parameter int NDI = 64,
    parameter int NET_ANALOG_IN = 32,
    parameter int NDO = 64,
    parameter int NAO = 16,
    parameter int AW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [7:0][3:0] gate_in,
    output logic [7:0] gate_out,
    input wire logic [3:0] cursor_key,
    input wire logic [3:0] text_display_panel_cursor_key,
    input wire logic [3:0] panel_key,
    input wire logic [NDI-1:0] net_digital_in,
    input wire logic [NET_ANALOG_IN-1:0][AW-1:0] net_analog_in,
    output logic [NDO-1:0] net_digital_out,
    output logic [NAO-1:0][AW-1:0] net_analog_out,
    input wire logic shift_load,
    input wire logic [31:0] shift_data,
    output logic [31:0] shift_bits,
    output logic startup_flag,
    output logic white_backlight_base,
    output logic white_backlight_panel,
    output logic amber_backlight_base,
    output logic amber_backlight_panel,
    output logic red_backlight_base,
    output logic red_backlight_panel,
    output logic charset_select_flag,
    output logic cycle_tick
);

    localparam int CW = $clog2(CYCLE_CLKS + 1);

    logic [2:0] ctrl_r;
    logic_engine_pkg::flags_s flag_wr_r;
    logic_engine_pkg::flags_s flags_r;
    logic_engine_pkg::keys_s keys_r;
    logic_engine_pkg::seq_e seq_r;
    logic [CW-1:0] cnt_r;
    logic tick_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [7:0][11:0] gcfg_r;
    logic [7:0][3:0] res;
    logic [7:0][3:0] prev_r;
    logic [7:0] gate_r;
    logic [31:0] shift_r;
    logic [NDI-1:0] ndi_r;
    logic [NDO-1:0] ndo_wr_r;
    logic [NDO-1:0] ndo_r;
    logic [NAO-1:0][AW-1:0] nao_r;
    logic [4:0] aidx_r;
    logic req;
    logic take;

    assign req = read | write;
    assign take = req & ~wait_r;

    // resolve one gate input: source select, open default, then inversion
    function automatic logic pin_val(input logic [2:0] cfg, input logic pin, input logic open_v);
        logic_engine_pkg::pin_cfg_s c;
        logic v;
        c = cfg;
        case (c.src)
            logic_engine_pkg::SRC_OPEN: v = open_v;
            logic_engine_pkg::SRC_PIN: v = pin;
            logic_engine_pkg::SRC_LO: v = 1'b0;
            default: v = 1'b1;
        endcase
        return v ^ c.inv;
    endfunction

    // open inputs: 1 for the and/nand family, 0 for the rest
    generate
        for (genvar b = 0; b < 8; b++) begin : g_blk
            for (genvar i = 0; i < 4; i++) begin : g_pin
                assign res[b][i] = pin_val(gcfg_r[b][3*i +: 3], gate_in[b][i],
                                           b < 4);
            end
        end
    endgenerate

    // program cycle sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seq_r <= logic_engine_pkg::ST_IDLE;
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            case (seq_r)
                logic_engine_pkg::ST_IDLE: begin
                    cnt_r <= '0;
                    if (ctrl_r[`CTRL_RUN_BIT]) begin
                        seq_r <= logic_engine_pkg::ST_FIRST;
                    end
                end
                default: begin
                    // first stays visible at the edge that applies its tick
                    if (tick_r) begin
                        seq_r <= logic_engine_pkg::ST_RUN;
                    end
                    if (!ctrl_r[`CTRL_RUN_BIT]) begin
                        seq_r <= logic_engine_pkg::ST_IDLE;
                    end else if (cnt_r == CW'(CYCLE_CLKS - 1)) begin
                        cnt_r <= '0;
                        tick_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
            endcase
        end
    end

    // special flags change only at a cycle boundary
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_r <= `FLAG_RESET;
        end else if (seq_r == logic_engine_pkg::ST_IDLE && ctrl_r[`CTRL_RUN_BIT]) begin
            flags_r.startup <= 1'b1;
        end else if (tick_r) begin
            flags_r <= flag_wr_r;
            if (seq_r == logic_engine_pkg::ST_FIRST) begin
                flags_r.startup <= 1'b0;
            end else begin
                flags_r.startup <= flag_wr_r.startup;
            end
            if (!ctrl_r[`CTRL_CSUSED_BIT]) begin
                flags_r.charset <= ctrl_r[`CTRL_CSCFG_BIT];
            end else begin
                flags_r.charset <= flag_wr_r.charset;
            end
        end
    end

    // input image and gate outputs, taken once per cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            keys_r <= '0;
            ndi_r <= '0;
            prev_r <= '1;
            gate_r <= '0;
        end else if (tick_r) begin
            keys_r.cursor_key <= cursor_key | text_display_panel_cursor_key;
            keys_r.panel_key <= panel_key;
            ndi_r <= net_digital_in;
            prev_r <= res;
            gate_r[0] <= &res[0];
            gate_r[1] <= (&res[1]) & ~(&prev_r[1]);
            gate_r[2] <= ~(&res[2]);
            gate_r[3] <= ~(&res[3]) & (&prev_r[3]);
            gate_r[4] <= |res[4];
            gate_r[5] <= ~(|res[5]);
            gate_r[6] <= res[6][0] ^ res[6][1];
            gate_r[7] <= ~res[7][0];
        end
    end

    // shift bits: only the shift function port may load them
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_r <= '0;
        end else if (shift_load) begin
            shift_r <= shift_data;
        end
    end

    // network digital outputs follow their written image at the boundary; analog outputs take bus writes at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ndo_r <= '0;
        end else if (tick_r) begin
            ndo_r <= ndo_wr_r;
        end
    end

    // avalon handshake: one wait cycle, then the access completes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(req & wait_r);
        end
    end

    // register writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RESET;
            flag_wr_r <= `FLAG_RESET;
            gcfg_r <= {8{`GCFG_RESET}};
            ndo_wr_r <= '0;
            nao_r <= '0;
            aidx_r <= '0;
        end else if (take && write) begin
            if (address == `ADDR_CTRL) begin
                ctrl_r <= writedata[2:0];
            end else if (address == `ADDR_FLAG_WR) begin
                flag_wr_r <= writedata[7:0];
            end else if (address >= `ADDR_GCFG0 && address <= `ADDR_GCFG3) begin
                gcfg_r[{address[3:2], 1'b0}] <= writedata[11:0];
                gcfg_r[{address[3:2], 1'b1}] <= writedata[27:16];
            end else if (address == `ADDR_NDO_LO) begin
                ndo_wr_r[31:0] <= writedata;
            end else if (address == `ADDR_NDO_HI) begin
                ndo_wr_r[NDO-1:32] <= writedata[NDO-33:0];
            end else if (address == `ADDR_AIDX) begin
                aidx_r <= writedata[4:0];
            end else if (address == `ADDR_ADATA && 32'(aidx_r) < NAO) begin
                nao_r[aidx_r[3:0]] <= writedata[AW-1:0];
            end
        end
    end

    // read data prepared in the wait cycle so it stands at the taking edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= '0;
        end else if (read && wait_r) begin
            if (address == `ADDR_CTRL) begin
                rdata_r <= {29'h0, ctrl_r};
            end else if (address == `ADDR_FLAG_WR) begin
                rdata_r <= {24'h0, flag_wr_r};
            end else if (address == `ADDR_FLAG_RD) begin
                rdata_r <= {24'h0, flags_r};
            end else if (address == `ADDR_STATUS) begin
                rdata_r <= {14'h0, seq_r, gate_r, 8'h0};
            end else if (address >= `ADDR_GCFG0 && address <= `ADDR_GCFG3) begin
                rdata_r <= {4'h0, gcfg_r[{address[3:2], 1'b1}],
                            4'h0, gcfg_r[{address[3:2], 1'b0}]};
            end else if (address == `ADDR_KEYS) begin
                rdata_r <= {24'h0, keys_r};
            end else if (address == `ADDR_SHIFT) begin
                rdata_r <= shift_r;
            end else if (address == `ADDR_NDI_LO) begin
                rdata_r <= ndi_r[31:0];
            end else if (address == `ADDR_NDI_HI) begin
                rdata_r <= ndi_r[NDI-1:32];
            end else if (address == `ADDR_NDO_LO) begin
                rdata_r <= ndo_wr_r[31:0];
            end else if (address == `ADDR_NDO_HI) begin
                rdata_r <= ndo_wr_r[NDO-1:32];
            end else if (address == `ADDR_AIDX) begin
                rdata_r <= {27'h0, aidx_r};
            end else if (address == `ADDR_ADATA && 32'(aidx_r) < NET_ANALOG_IN) begin
                rdata_r <= 32'(net_analog_in[aidx_r]);
            end else begin
                rdata_r <= '0;
            end
        end
    end

    assign readdata = rdata_r;
    assign waitrequest = wait_r;
    assign gate_out = gate_r;
    assign shift_bits = shift_r;
    assign net_digital_out = ndo_r;
    assign net_analog_out = nao_r;
    assign cycle_tick = tick_r;
    assign startup_flag = flags_r.startup;
    assign white_backlight_base = flags_r.white_base;
    assign white_backlight_panel = flags_r.white_panel;
    assign amber_backlight_base = flags_r.amber_base;
    assign amber_backlight_panel = flags_r.amber_panel;
    assign red_backlight_base = flags_r.red_base;
    assign red_backlight_panel = flags_r.red_panel;
    assign charset_select_flag = flags_r.charset;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_req_wait;
        req && wait_r;
    endsequence
    sequence s_done;
        !wait_r ##1 wait_r;
    endsequence

    a_bus_wait_one: assert property (s_req_wait |=> s_done)
        else $error("waitrequest not low for exactly one cycle");
    a_startup_clear: assert property (tick_r && seq_r == logic_engine_pkg::ST_FIRST
        |=> !flags_r.startup)
        else $error("startup flag not cleared after first cycle");
    a_flags_hold: assert property (!tick_r && seq_r != logic_engine_pkg::ST_IDLE
        |=> $stable(flags_r))
        else $error("flags changed inside a program cycle");
    a_charset_cfg: assert property (tick_r && !ctrl_r[`CTRL_CSUSED_BIT]
        |=> flags_r.charset == $past(ctrl_r[`CTRL_CSCFG_BIT]))
        else $error("charset not taken from configuration");
    a_and_gate: assert property (tick_r |=> gate_r[0] == &$past(res[0]))
        else $error("and output wrong");
    a_edge_and: assert property (tick_r
        |=> gate_r[1] == ((&$past(res[1])) && !(&$past(prev_r[1]))))
        else $error("edge and output wrong");
    a_nand_gate: assert property (tick_r |=> gate_r[2] == !(&$past(res[2])))
        else $error("nand output wrong");
    a_edge_nand: assert property (tick_r |=> gate_r[3] ==
        (!(&$past(res[3])) && (&$past(prev_r[3]))))
        else $error("edge nand output wrong");
    a_shift_ro: assert property (!shift_load |=> $stable(shift_r))
        else $error("shift bits changed without the shift function");
    a_gate_hold: assert property (!tick_r |=> $stable(gate_r))
        else $error("gate outputs changed between cycles");

endmodule // logic_engine

// ### tb/panel_peer_model.sv
// operator panel and network peer stand-in for the logic engine bench
// assumes the bench changes key and network levels at clock edges
`timescale 1ns/1ps

module panel_peer_model (
    input wire logic [11:0] key_cmd,
    input wire logic [63:0] ndi_cmd,
    output logic [3:0] cursor_key,
    output logic [3:0] panel_cursor_key,
    output logic [3:0] panel_key,
    output logic [63:0] net_digital_in,
    output logic [31:0][15:0] net_analog_in
);
    assign cursor_key = key_cmd[3:0];
    assign panel_cursor_key = key_cmd[7:4];
    assign panel_key = key_cmd[11:8];
    assign net_digital_in = ndi_cmd;
    // each analog word carries its own index so a wrong pick shows
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            net_analog_in[i] = 16'ha000 + 16'(i);
        end
    end
endmodule // panel_peer_model

// ### tb/cyclic_logic_gate_blocks_tb_top.sv
// self-checking bench for the scan-cycle logic engine
// assumes the config header, package and panel_peer_model are compiled first
`timescale 1ns/1ps
`include "logic_engine_cfg.svh"

module cyclic_logic_gate_blocks_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata, rd, shift_bits;
    logic waitrequest, cycle_tick;
    logic [7:0][3:0] gate_in = '0;
    logic [7:0] gate_out;
    logic [11:0] key_cmd = 12'h000;
    logic [63:0] ndi_cmd = 64'h0000_0000_0000_0000;
    logic [3:0] cursor_key, panel_cursor_key, panel_key;
    logic [63:0] net_digital_in, net_digital_out;
    logic [31:0][15:0] net_analog_in;
    logic [15:0][15:0] net_analog_out;
    logic shift_load = 1'b0;
    logic [31:0] shift_data = 32'h0000_0000;
    wire [7:0] flags_v;
    int err_total = 0;
    int cmp_count = 0;

    always #5 clk = ~clk;

    panel_peer_model u_peer (.key_cmd(key_cmd), .ndi_cmd(ndi_cmd), .cursor_key(cursor_key),
        .panel_cursor_key(panel_cursor_key), .panel_key(panel_key),
        .net_digital_in(net_digital_in), .net_analog_in(net_analog_in));

    logic_engine #(.CYCLE_CLKS(16)) u_dut (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .gate_in(gate_in), .gate_out(gate_out),
        .cursor_key(cursor_key), .text_display_panel_cursor_key(panel_cursor_key),
        .panel_key(panel_key), .net_digital_in(net_digital_in),
        .net_analog_in(net_analog_in), .net_digital_out(net_digital_out),
        .net_analog_out(net_analog_out), .shift_load(shift_load), .shift_data(shift_data),
        .shift_bits(shift_bits), .startup_flag(flags_v[0]),
        .white_backlight_base(flags_v[1]), .white_backlight_panel(flags_v[2]),
        .amber_backlight_base(flags_v[3]), .amber_backlight_panel(flags_v[4]),
        .red_backlight_base(flags_v[5]), .red_backlight_panel(flags_v[6]),
        .charset_select_flag(flags_v[7]), .cycle_tick(cycle_tick));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    // returns one clock after the edge that applies a program cycle end
    task automatic tick();
        do begin
            @(posedge clk);
        end while (cycle_tick !== 1'b1);
        @(posedge clk);
        #1;
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic t_startup();
        check({waitrequest, gate_out, flags_v}, {1'b1, 16'h0000});
        bus(1'b1, `ADDR_CTRL, 32'h0000_0001);
        @(posedge clk);
        #1;
        check(flags_v[0], 1'b1);
        tick();
        check(flags_v[0], 1'b0);
        bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0001);
        check(flags_v[0], 1'b0);
        tick();
        check(flags_v[0], 1'b1);
        bus(1'b0, `ADDR_FLAG_RD, 32'h0000_0000);
        check(rd[7:0], 8'h01);
        bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0000);
        tick();
        check(flags_v[0], 1'b0);
        // restart with a pending startup bit: the first cycle must still clear it
        bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0001);
        bus(1'b1, `ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, `ADDR_CTRL, 32'h0000_0001);
        @(posedge clk);
        #1;
        check(flags_v[0], 1'b1);
        tick();
        check(flags_v[0], 1'b0);
        tick();
        check(flags_v[0], 1'b1);
    endtask

    task automatic t_flags();
        for (int b = 1; b < 7; b++) begin
            bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0001 << b);
            tick();
            check(flags_v, 8'h01 << b);
        end
        bus(1'b1, `ADDR_CTRL, 32'h0000_0003);
        bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0000);
        tick();
        check(flags_v[7], 1'b1);
        bus(1'b1, `ADDR_CTRL, 32'h0000_0005);
        bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0080);
        tick();
        check(flags_v[7], 1'b1);
        bus(1'b1, `ADDR_FLAG_WR, 32'h0000_0000);
        tick();
        check(flags_v[7], 1'b0);
    endtask

    task automatic t_gates();
        logic [3:0] p;
        logic [3:0] v;
        logic [7:0] e;
        p = 4'hf;
        @(posedge clk);
        gate_in <= '1;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'(`ADDR_GCFG0 + 4 * k), 32'h0249_0249);
        end
        tick();
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            @(posedge clk);
            gate_in <= {8{v}};
            tick();
            e = {~v[0], v[0] ^ v[1], ~|v, |v, ~&v & &p, ~&v, &v & ~&p, &v};
            check(gate_out, e);
            p = v;
        end
        // and block: in0 pin inverted, in1 hi, in2 open, in3 lo inverted
        bus(1'b1, `ADDR_GCFG0, 32'h0249_0c1d);
        bus(1'b1, 8'h18, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            gate_in[0] <= 4'(i);
            tick();
            check({gate_out[5:4], gate_out[0]}, {2'b10, 1'(1 - i)});
        end
    endtask

    task automatic t_io();
        @(posedge clk);
        key_cmd <= 12'ha25;
        ndi_cmd <= 64'h8000_0001_c000_0003;
        shift_data <= 32'h1234_5678;
        shift_load <= 1'b1;
        @(posedge clk);
        shift_load <= 1'b0;
        tick();
        check(shift_bits, 32'h1234_5678);
        bus(1'b1, `ADDR_SHIFT, 32'h0000_0000);
        bus(1'b0, `ADDR_SHIFT, 32'h0000_0000);
        check(rd, 32'h1234_5678);
        bus(1'b0, `ADDR_KEYS, 32'h0000_0000);
        check(rd[7:0], 8'ha7);
        bus(1'b0, `ADDR_NDI_HI, 32'h0000_0000);
        check(rd, 32'h8000_0001);
        bus(1'b1, `ADDR_NDO_LO, 32'h0000_0001);
        bus(1'b1, `ADDR_NDO_HI, 32'h8000_0000);
        bus(1'b1, `ADDR_AIDX, 32'h0000_000f);
        bus(1'b1, `ADDR_ADATA, 32'h0000_5a5a);
        bus(1'b1, `ADDR_AIDX, 32'h0000_001f);
        bus(1'b0, `ADDR_ADATA, 32'h0000_0000);
        check(rd, 32'h0000_a01f);
        tick();
        check(net_digital_out, 64'h8000_0000_0000_0001);
        check(net_analog_out[15], 16'h5a5a);
        bus(1'b0, 8'hfc, 32'h0000_0000);
        check(rd, 32'h0000_0000);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_startup();
        t_flags();
        t_gates();
        t_io();
        wrap_up();
    end

    // about 40 program cycles are needed; this allows many times that
    initial begin
        #200_000;
        err_total++;
        wrap_up();
    end
endmodule // cyclic_logic_gate_blocks_tb_top
